// [src/dsssc_regs.vh]
// Constants for the display sweep and store control block
`ifndef DSSSC_REGS_VH
`define DSSSC_REGS_VH
// Clock period in ns
`define DSSSC_CLK_NS 8
// Lockout interval in ns, long enough to swallow a strobed pulse pair
`define DSSSC_LOCK_NS 1600
// Lockout count, rounded down, at least one cycle
`define DSSSC_LOCK_CYC (`DSSSC_LOCK_NS / `DSSSC_CLK_NS)
// Stop pulse width in ns
`define DSSSC_STOP_NS 2000
// Stop pulse count, rounded down
`define DSSSC_STOP_CYC (`DSSSC_STOP_NS / `DSSSC_CLK_NS)
// Timer width
`define DSSSC_TMR_W 9
// Range numbers
`define DSSSC_RANGE_LAST_FAST 5'h07
`define DSSSC_RANGE_LAST_ADD 5'h06
`define DSSSC_RANGE_FIRST_SLOW 5'h13
`define DSSSC_RANGE_LAST 5'h17
// Strobe rate codes
`define DSSSC_RATE_FULL 2'h0
`define DSSSC_RATE_HALF 2'h1
`define DSSSC_RATE_QUARTER 2'h2
// Register bus offsets
`define DSSSC_OFS_CTRL 4'h0
`define DSSSC_OFS_STAT 4'h4
// Control field positions
`define DSSSC_CTRL_RANGE_LSB 0
`define DSSSC_CTRL_RANGE_MSB 4
`define DSSSC_CTRL_DUAL 5
`define DSSSC_CTRL_DIV2 6
`define DSSSC_CTRL_DIV4 7
// Control reset value
`define DSSSC_CTRL_RST 8'h01
`endif

// [src/dsssc_ctrl.v]
// Display sweep, sample strobe and store sequencing control
`timescale 1ns/1ps
// Functional notes
// RULE1: Refresh uses read MSB, roll uses equality
// RULE2: Roll fast ranges unstored use read counter
// RULE3: Stored or full hold stops write counter
// RULE4: First request starts fixed lockout interval
// RULE5: Lockout end launches two microsecond stop
// RULE6: Stop pulse clears display ramp
// RULE7: Toggle arms strobe counter, second strobe starts
// RULE8: Start every second request, stop every one
// RULE9: Strobes at full, half or quarter rate
// RULE10: Dual trace passes strobes by read LSB
// RULE11: Roll fast unstored adds read clock per two counts
// RULE12: Extra clock is next phase three, phase five clears
// RULE13: Selector gives normal, refreshed, roll indicators
// RULE14: Slow ranges turn normal into refreshed
// RULE15: One mode lamp, none while stored
// RULE16: Full hold blocks write counter clocks
// RULE17: Half hold forces write LSB high
// RULE18: Half hold forces dual trace ramp toggled LSB
// RULE19: Release clears state and lamps, enables trigger; in roll mode trigger enable follows arming and stays low until store
// RULE20: Store sets arming and lights indicator_a
// RULE21: Write done lights stored, trigger enable low
// RULE22: Fast refresh holds trigger off two sweeps
// RULE23: Trigger clears arming, lights indicator_b
// RULE24: Reset starts released, idle, no hold
module dsssc_ctrl (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // System phase pulses
    input wire phase_three_pulse,
    input wire phase_four_strobe,
    input wire phase_five_pulse,
    // Front panel
    input wire [1:0] display_mode_selector,
    input wire full_store_hold_button,
    input wire half_store_hold_button,
    input wire store_button,
    input wire release_button,
    // Store side events
    input wire trigger_event,
    input wire write_done,
    input wire range_div_pulse,
    input wire read_msb,
    input wire read_lsb,
    input wire wr_rd_equal,
    input wire write_lsb_in,
    input wire ramp_running,
    // Ramp generator
    output reg ramp_clear_q,
    output reg ramp_start_q,
    // Store counters
    output reg write_clk_q,
    output reg write_address_lsb_q,
    output reg read_extra_clk_q,
    output reg sample_strobe_q,
    // Indicators and lines
    output reg normal_mode_line_q,
    output reg roll_line_q,
    output reg led_normal_q,
    output reg led_refresh_q,
    output reg led_roll_q,
    output reg indicator_a_q,
    output reg indicator_b_q,
    output reg led_stored_q,
    output reg trigger_enable_q,
    output reg dual_trace_q
);
`include "dsssc_regs.vh"

    // One clock domain; every panel and store input is taken as already
    // synchronous to clk_sys, so no synchronisers are placed here.

    // Selector codes
    localparam SEL_UP = 2'h0;
    localparam SEL_MID = 2'h1;
    localparam SEL_LOW = 2'h2;
    // Sweep sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_LOCK = 2'h1;
    localparam ST_STOP = 2'h2;
    // Timer loads, cut to the timer width on purpose
    localparam [31:0] LOCK_LOAD = `DSSSC_LOCK_CYC - 1;
    localparam [31:0] STOP_LOAD = `DSSSC_STOP_CYC - 1;

    // Control register fields
    reg [7:0] ctrl_q;
    wire [4:0] range_no = ctrl_q[`DSSSC_CTRL_RANGE_MSB:`DSSSC_CTRL_RANGE_LSB];
    // Store state
    reg arm_q;
    reg trig_q;
    reg stored_q;
    // Sequencer
    reg [1:0] st_q;
    reg [`DSSSC_TMR_W-1:0] tmr_q;
    reg toggle_q;
    reg [1:0] strobe_cnt_q;
    // Request edge detect
    reg req_src_q;
    // Extra clock stages
    reg msb_q;
    reg div_q;
    reg add_arm_q;
    reg add_sent_q; // Extra clock already issued for this arming
    // Strobe divider
    reg [1:0] rate_cnt_q;
    // Ramp edge for dual sweep counting
    reg ramp_q;
    reg [1:0] sweep_cnt_q;
    reg holdoff_q;

    // Range within an inclusive window
    function in_range;
        input [4:0] r;
        input [4:0] lo;
        input [4:0] hi;
        begin
            in_range = (r >= lo) && (r <= hi);
        end
    endfunction

    // Mode decode
    // Code three on the selector falls through to refreshed.
    wire slow = in_range(range_no, `DSSSC_RANGE_FIRST_SLOW, `DSSSC_RANGE_LAST);
    wire is_roll = (display_mode_selector == SEL_LOW);
    wire is_normal_mode_line = (display_mode_selector == SEL_UP) && !slow; // RULE14
    wire is_refr = !is_roll && !is_normal_mode_line; // RULE14
    wire fast7 = in_range(range_no, 5'h01, `DSSSC_RANGE_LAST_FAST);
    wire fast6 = in_range(range_no, 5'h01, `DSSSC_RANGE_LAST_ADD);
    wire half_hold = half_store_hold_button;
    wire dual = ctrl_q[`DSSSC_CTRL_DUAL] || half_hold; // RULE18

    // On the fastest roll ranges both counters step together and never meet,
    // so the read counter stands in until writing stops. Once the store is
    // held, either by the stored state or by full hold, the write counter
    // stands still and the equality strobe marks each pass of the reader.
    // Start source select
    wire use_eq = is_roll && !(fast7 && !stored_q && !full_store_hold_button); // RULE1 RULE2
    wire req_src = use_eq ? (wr_rd_equal && phase_four_strobe) : read_msb; // RULE1 RULE3
    wire req = req_src && !req_src_q;

    // The quarter rate wins over the half rate when both bits are set.
    // In dual trace only strobes on odd read addresses pass, so the two
    // traces are sampled from alternate store locations.
    // Gated strobe before dual selection
    wire rate_hit = ctrl_q[`DSSSC_CTRL_DIV4] ? (rate_cnt_q == 2'h3) :
                    ctrl_q[`DSSSC_CTRL_DIV2] ? rate_cnt_q[0] : 1'b1; // RULE9
    wire gated = phase_four_strobe && rate_hit; // RULE9
    wire strobe = gated && (!dual || read_lsb); // RULE10

    // Unmapped reads return zero; read data stands for one cycle only.
    // Register access
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `DSSSC_CTRL_RST;
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            // Control write
            if (reg_wr && reg_addr == `DSSSC_OFS_CTRL) begin
                ctrl_q <= reg_wdata[7:0];
            end
            // Read data one cycle later
            if (reg_rd) begin
                case (reg_addr)
                    `DSSSC_OFS_CTRL: reg_rdata_q <= {24'h00_0000, ctrl_q};
                    `DSSSC_OFS_STAT: reg_rdata_q <= {24'h00_0000, st_q, toggle_q,
                        holdoff_q, stored_q, trig_q, arm_q, is_roll};
                    default: reg_rdata_q <= 32'h0000_0000;
                endcase
            end else begin
                reg_rdata_q <= 32'h0000_0000;
            end
        end
    end

    // Release wins over store, and store over trigger and write done.
    // Triggers are ignored while the two sweep hold off is running.
    // Store, arm and trigger sequencing
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            arm_q <= 1'b0; // RULE24
            trig_q <= 1'b0;
            stored_q <= 1'b0;
        end else if (release_button) begin
            arm_q <= 1'b0; // RULE19
            trig_q <= 1'b0;
            stored_q <= 1'b0;
        end else if (store_button) begin
            arm_q <= 1'b1; // RULE20
            stored_q <= 1'b0;
        end else if (arm_q && trigger_event && !holdoff_q) begin
            arm_q <= 1'b0; // RULE23
            trig_q <= 1'b1;
        end else if (trig_q && write_done) begin
            trig_q <= 1'b0; // RULE21
            stored_q <= 1'b1;
        end
    end

    // On the fast refreshed ranges writing breaks into reading; without
    // this hold off rapid triggers would starve the display of a full
    // read. Leaving those ranges or pressing release drops the hold off.
    // Two sweep hold off after writing on fast refreshed ranges
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ramp_q <= 1'b0;
            sweep_cnt_q <= 2'h0;
            holdoff_q <= 1'b0;
        end else begin
            ramp_q <= ramp_running;
            if (!(is_refr && fast6) || release_button) begin
                holdoff_q <= 1'b0;
                sweep_cnt_q <= 2'h0;
            end else if (trig_q && write_done) begin
                holdoff_q <= 1'b1; // RULE22
                sweep_cnt_q <= 2'h0;
            end else if (holdoff_q && ramp_q && !ramp_running) begin
                // Count completed sweeps
                if (sweep_cnt_q == 2'h1) begin
                    holdoff_q <= 1'b0; // RULE22
                end
                sweep_cnt_q <= sweep_cnt_q + 2'h1;
            end
        end
    end

    // Roll mode equality arrives as a pulse pair because the read counter
    // steps at half rate; the lockout swallows the second pulse. The stop
    // pulse always follows, but the toggle lets only every other request
    // reach the start counter, giving stop-start, stop, stop-start.
    // A stop with no sweep running is harmless: the ramp is already idle.
    // Sweep lockout, stop pulse and start toggling
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE; // RULE24
            tmr_q <= {`DSSSC_TMR_W{1'b0}};
            toggle_q <= 1'b0;
            strobe_cnt_q <= 2'h0;
            req_src_q <= 1'b0;
            ramp_clear_q <= 1'b0;
            ramp_start_q <= 1'b0;
        end else begin
            req_src_q <= req_src;
            ramp_start_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    // First request starts lockout
                    if (req) begin
                        st_q <= ST_LOCK; // RULE4
                        tmr_q <= LOCK_LOAD[`DSSSC_TMR_W-1:0];
                    end
                end
                ST_LOCK: begin
                    // Requests ignored here
                    if (tmr_q == {`DSSSC_TMR_W{1'b0}}) begin
                        st_q <= ST_STOP; // RULE5
                        tmr_q <= STOP_LOAD[`DSSSC_TMR_W-1:0];
                        ramp_clear_q <= 1'b1; // RULE6
                    end else begin
                        tmr_q <= tmr_q - 1'b1; // RULE4
                    end
                end
                ST_STOP: begin
                    // Stop pulse held, then toggle
                    if (tmr_q == {`DSSSC_TMR_W{1'b0}}) begin
                        st_q <= ST_IDLE;
                        ramp_clear_q <= 1'b0; // RULE6
                        toggle_q <= !toggle_q; // RULE8
                        strobe_cnt_q <= 2'h0; // RULE7
                    end else begin
                        tmr_q <= tmr_q - 1'b1; // RULE5
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
            // Strobe counter runs only while toggle set and not stopping
            // Count saturates at two, so later strobes have no effect
            if (toggle_q && st_q != ST_STOP && gated && strobe_cnt_q != 2'h2) begin
                strobe_cnt_q <= strobe_cnt_q + 2'h1; // RULE7
                if (strobe_cnt_q == 2'h1) begin
                    ramp_start_q <= 1'b1; // RULE7 RULE8
                end
            end
        end
    end

    // Extra read clock insertion
    // The add_arm_q stage waits for the next phase three, whatever phase it
    // was armed in; phase five only disarms once that pulse has gone out,
    // so each arming adds exactly one read clock.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msb_q <= 1'b0;
            div_q <= 1'b0;
            add_arm_q <= 1'b0;
            add_sent_q <= 1'b0;
            read_extra_clk_q <= 1'b0;
        end else begin
            msb_q <= read_msb;
            read_extra_clk_q <= 1'b0;
            // Issue the one extra clock on phase three
            if (add_arm_q && !add_sent_q && phase_three_pulse) begin
                read_extra_clk_q <= 1'b1; // RULE12
                add_sent_q <= 1'b1;
            end
            // Following phase five disarms
            if (add_arm_q && add_sent_q && phase_five_pulse) begin
                add_arm_q <= 1'b0; // RULE12
                add_sent_q <= 1'b0;
            end
            // Count full read counts on MSB fall; a new arming wins
            if (msb_q && !read_msb) begin
                div_q <= !div_q;
                if (div_q && is_roll && fast6 && !stored_q) begin
                    add_arm_q <= 1'b1; // RULE11
                    add_sent_q <= 1'b0;
                end
            end
        end
    end

    // Every panel output is registered, so lamps follow their state bits
    // one clock later. The stored lamp blanks all three mode lamps.
    // Full hold and the stored state both starve the write counter.
    // Strobes, write path and panel outputs
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rate_cnt_q <= 2'h0;
            sample_strobe_q <= 1'b0;
            write_clk_q <= 1'b0;
            write_address_lsb_q <= 1'b0;
            normal_mode_line_q <= 1'b0;
            roll_line_q <= 1'b0;
            led_normal_q <= 1'b0;
            led_refresh_q <= 1'b0;
            led_roll_q <= 1'b0;
            indicator_a_q <= 1'b0;
            indicator_b_q <= 1'b0;
            led_stored_q <= 1'b0;
            trigger_enable_q <= 1'b1; // RULE24
            dual_trace_q <= 1'b0;
        end else begin
            if (phase_four_strobe) begin
                rate_cnt_q <= rate_cnt_q + 2'h1;
            end
            sample_strobe_q <= strobe; // RULE10
            write_clk_q <= range_div_pulse && !full_store_hold_button && !stored_q; // RULE16 RULE3
            write_address_lsb_q <= write_lsb_in || half_hold; // RULE17
            normal_mode_line_q <= is_normal_mode_line; // RULE13
            roll_line_q <= is_roll; // RULE13
            led_normal_q <= is_normal_mode_line && !stored_q; // RULE15
            led_refresh_q <= is_refr && !stored_q; // RULE15
            led_roll_q <= is_roll && !stored_q; // RULE15
            indicator_a_q <= arm_q; // RULE20
            indicator_b_q <= trig_q; // RULE23
            led_stored_q <= stored_q; // RULE21
            dual_trace_q <= dual; // RULE18
            // Trigger enable per mode
            if (holdoff_q) begin
                trigger_enable_q <= 1'b0; // RULE22
            end else if (is_roll) begin
                trigger_enable_q <= arm_q;
            end else begin
                trigger_enable_q <= !(trig_q || stored_q) || arm_q; // RULE19 RULE21
            end
        end
    end

endmodule // dsssc_ctrl

// [bench/dsssc_panel.sv]
// Phase pulse source and display ramp model
`timescale 1ns/1ps
module dsssc_panel (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Ramp control
    input wire ramp_start_q,
    input wire ramp_clear_q,
    // Phases and ramp state
    output logic phase_three_pulse,
    output logic phase_four_strobe,
    output logic phase_five_pulse,
    output logic ramp_running
);
    logic [2:0] ph_q; // Phase slot, five per period
    logic [7:0] len_q; // Sweep time left
    // Phase ring, and a ramp that a stop pulse cuts short
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ph_q <= 3'h0;
            len_q <= 8'h00;
        end else begin
            ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
            if (ramp_clear_q) len_q <= 8'h00;
            else if (ramp_start_q) len_q <= 8'h64;
            else if (len_q != 8'h00) len_q <= len_q - 8'h01;
        end
    end
    assign phase_three_pulse = (ph_q == 3'h2);
    assign phase_four_strobe = (ph_q == 3'h3);
    assign phase_five_pulse = (ph_q == 3'h4);
    assign ramp_running = (len_q != 8'h00);
endmodule // dsssc_panel

// [bench/dsssc_chk.sv]
// Assertions on sweep, lamp and hold outputs
`timescale 1ns/1ps
module dsssc_chk (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Panel inputs
    input wire full_store_hold_button,
    input wire half_store_hold_button,
    input wire release_button,
    // Block outputs
    input wire ramp_clear_q,
    input wire ramp_start_q,
    input wire write_clk_q,
    input wire write_address_lsb_q,
    input wire dual_trace_q,
    input wire led_normal_q,
    input wire led_refresh_q,
    input wire led_roll_q,
    input wire led_stored_q,
    input wire indicator_a_q,
    input wire indicator_b_q,
    input wire trigger_enable_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reg [8:0] hi_q; // Stop pulse cycles so far
    // Length of the running stop pulse
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            hi_q <= 9'h000;
        else
            hi_q <= ramp_clear_q ? hi_q + 9'h001 : 9'h000;
    end
    chk_stop_len: assert property ($fell(ramp_clear_q) |-> hi_q == 9'h0fa)
        else $error("stop width");
    chk_start_once: assert property (ramp_start_q |=> !ramp_start_q)
        else $error("start width");
    chk_start_clean: assert property (ramp_start_q |-> !ramp_clear_q && !$past(ramp_clear_q))
        else $error("start in stop");
    chk_one_lamp: assert property ($past(rstn) && !led_stored_q && !$past(led_stored_q)
        |-> $onehot({led_normal_q, led_refresh_q, led_roll_q}))
        else $error("lamps");
    chk_stored_dark: assert property (led_stored_q && $past(led_stored_q)
        |-> !(led_normal_q | led_refresh_q | led_roll_q) && !trigger_enable_q)
        else $error("stored lamps");
    chk_full_block: assert property (full_store_hold_button && $past(full_store_hold_button)
        |-> !write_clk_q)
        else $error("write clock");
    chk_half_hold: assert property ($past(half_store_hold_button) && $past(rstn)
        |-> write_address_lsb_q && dual_trace_q)
        else $error("half hold");
    chk_release_off: assert property ($past(release_button, 2) && $past(rstn, 2)
        |-> !indicator_a_q && !indicator_b_q && !led_stored_q)
        else $error("release");
endmodule // dsssc_chk

// [bench/tb_dsssc_ctrl.sv]
// Bench for the sweep and store control block
`timescale 1ns/1ps
`include "dsssc_regs.vh"
module tb_dsssc_ctrl;
    logic clk_sys = 1'b0;
    logic rstn;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q;
    logic [1:0] display_mode_selector;
    logic [6:0] btn; // Store, release, trigger, done, divider, read msb, equal
    logic reg_wr, reg_rd, full_store_hold_button, half_store_hold_button, store_button;
    logic release_button, trigger_event, write_done, range_div_pulse, read_msb, read_lsb;
    logic wr_rd_equal, write_lsb_in, ramp_running, phase_three_pulse, phase_four_strobe;
    logic phase_five_pulse, ramp_clear_q, ramp_start_q, write_clk_q, write_address_lsb_q;
    logic read_extra_clk_q, sample_strobe_q, normal_mode_line_q, roll_line_q, led_normal_q;
    logic led_refresh_q, led_roll_q, indicator_a_q, indicator_b_q, led_stored_q;
    logic trigger_enable_q, dual_trace_q, clr_p;
    int num_errors = 0, check_count = 0, n_clr = 0, n_st = 0, n_ex = 0, n_wc = 0, t, b;
    int n_ss = 0; // Sample strobes seen
    // Control value, expected strobes per 100 cycles
    logic [15:0] rate_tbl [6] = '{16'h0114, 16'h410a, 16'h8105, 16'hc105, 16'h2100, 16'h2114};
    // Mode, fast range, equal source, full hold, stop expected
    logic [5:0] tbl [6] = '{6'h14, 6'h25, 6'h20, 6'h29, 6'h2c, 6'h2f};
    assign {store_button, release_button, trigger_event, write_done} = btn[6:3];
    assign {range_div_pulse, read_msb, wr_rd_equal} = btn[2:0];
    always #4 clk_sys = ~clk_sys;
    dsssc_ctrl u_dut (.*);
    dsssc_panel u_panel (.*);
    // Event counters, sampled on the falling edge where outputs are settled
    always @(negedge clk_sys) begin
        n_clr += (ramp_clear_q === 1'b1 && clr_p !== 1'b1);
        clr_p = ramp_clear_q;
        n_st += (ramp_start_q === 1'b1);
        n_ex += (read_extra_clk_q === 1'b1);
        n_wc += (write_clk_q === 1'b1);
        n_ss += (sample_strobe_q === 1'b1);
    end
    task automatic check(input string nm, input logic [31:0] ex, got);
        check_count++;
        if (got !== ex) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic pulse(input int i, input int n);
        @(posedge clk_sys) btn[i] <= 1'b1;
        cyc(n);
        btn[i] <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ex);
        @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 check("read", ex, reg_rdata_q);
    endtask
    task automatic setm(input logic [1:0] s, input logic [31:0] c);
        display_mode_selector <= s;
        wr(`DSSSC_OFS_CTRL, c);
        cyc(3);
    endtask
    task conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        cyc(60000);
        num_errors++;
        conclude;
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, display_mode_selector, btn} = '0;
        {full_store_hold_button, half_store_hold_button, read_lsb, write_lsb_in} = '0;
        rstn = 1'b0;
        cyc(5);
        check("rst", 1, {ramp_clear_q, indicator_a_q, led_stored_q, trigger_enable_q});
        rstn <= 1'b1;
        rd(`DSSSC_OFS_CTRL, `DSSSC_CTRL_RST);
        wr(`DSSSC_OFS_CTRL, 32'h0000_008a);
        rd(`DSSSC_OFS_CTRL, 32'h0000_008a);
        rd(4'h8, 0);
        $display("registers done");
        for (int i = 0; i < 6; i++) begin
            setm(i % 3, (i < 3) ? 1 : 19);
            t = (i % 3 == 2) ? 1 : (i % 3 == 1 || i > 2) ? 2 : 4;
            check("lamps", t, {led_normal_q, led_refresh_q, led_roll_q});
            check("lines", {t[2], t[0]}, {normal_mode_line_q, roll_line_q});
        end
        $display("lamps done");
        setm(1, 10);
        b = n_st;
        for (int k = 0; k < 4; k++) begin
            t = n_clr;
            pulse(1, 20);
            pulse(1, 20);
            cyc(700);
            check("stops", t + 1, n_clr);
        end
        check("starts", b + 2, n_st);
        pulse(1, 1);
        for (t = 1; t < 600 && ramp_clear_q !== 1'b1; t++) cyc(1);
        check("lockout", 1, t > 198 && t < 204);
        cyc(700);
        $display("sweep done");
        foreach (tbl[i]) begin
            full_store_hold_button <= tbl[i][1];
            setm(tbl[i][5:4], tbl[i][3] ? 1 : 10);
            t = n_clr;
            pulse(tbl[i][2] ? 0 : 1, 20);
            cyc(700);
            check("source", tbl[i][0], n_clr - t);
        end
        full_store_hold_button <= 1'b0;
        $display("source done");
        for (int r = 6; r < 8; r++) begin
            setm(2, r);
            b = n_ex;
            repeat (4) begin
                pulse(1, 30);
                cyc(30);
            end
            check("extra", (r == 6) ? 2 : 0, n_ex - b);
            cyc(700);
        end
        $display("extra done");
        setm(1, 10);
        pulse(6, 1);
        cyc(3);
        check("indicator_a", 3'b101, {indicator_a_q, indicator_b_q, trigger_enable_q});
        rd(`DSSSC_OFS_STAT, 32'h0000_0002);
        pulse(4, 1);
        cyc(3);
        check("trig", 3'b010, {indicator_a_q, indicator_b_q, led_stored_q});
        pulse(3, 1);
        cyc(3);
        check("stored", 3'b010, {indicator_b_q, led_stored_q, trigger_enable_q});
        check("dark", 0, {led_normal_q, led_refresh_q, led_roll_q});
        pulse(5, 1);
        cyc(3);
        check("release", 3'b001, {indicator_a_q, led_stored_q, trigger_enable_q});
        setm(1, 3);
        for (int j = 6; j > 2; j--) pulse((j == 5) ? 4 : (j == 4) ? 3 : 6, 1);
        cyc(3);
        check("holdoff", 0, trigger_enable_q);
        repeat (4) begin
            pulse(1, 20);
            cyc(700);
        end
        check("holdoff end", 1, trigger_enable_q);
        pulse(5, 1);
        $display("store done");
        full_store_hold_button <= 1'b1;
        b = n_wc;
        repeat (3) pulse(2, 1);
        cyc(3);
        check("held", b, n_wc);
        full_store_hold_button <= 1'b0;
        repeat (3) pulse(2, 1);
        cyc(3);
        check("wclk", b + 3, n_wc);
        half_store_hold_button <= 1'b1;
        cyc(3);
        check("half", 2'b11, {write_address_lsb_q, dual_trace_q});
        half_store_hold_button <= 1'b0;
        $display("hold done");
        foreach (rate_tbl[k]) begin
            read_lsb <= (k == 5);
            setm(1, rate_tbl[k][15:8]);
            b = n_ss;
            cyc(100);
            check("strobes", rate_tbl[k][7:0], n_ss - b);
            check("dual", rate_tbl[k][13], dual_trace_q);
        end
        read_lsb <= 1'b0;
        $display("strobe done");
        conclude;
    end
endmodule // tb_dsssc_ctrl
bind dsssc_ctrl dsssc_chk u_chk (.*);
